// file: hdl/pdpsa_params.svh
// Constants for the per-channel DMA PCI start address registers
// How it works
// - One 32-bit PCI start address per channel
// - Read and write from peripheral and PCI
// - Cleared to zero on any reset
// - Low two bits ignored, longword transfers
// - Register keeps its contents once transfer starts
`ifndef PDPSA_PARAMS_SVH
`define PDPSA_PARAMS_SVH
`define PDPSA_CHANNELS 4
`define PDPSA_ADDR_W 32
`define PDPSA_RESET_VAL 32'h0000_0000
`define PDPSA_LOW_IGNORED 2
`define PDPSA_STEP 32'h0000_0004
`endif

// file: hdl/pdpsa_pkg.sv
// Types shared by the DMA PCI start address block
package pdpsa_pkg;
  typedef logic [31:0] pdpsa_word_t;
  typedef logic [1:0] pdpsa_chan_t;
endpackage : pdpsa_pkg

// file: hdl/pdpsa_regs.sv
// Per-channel PCI start address registers and working address counters
`timescale 1ns/1ps
`include "pdpsa_params.svh"
module pdpsa_regs (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic soft_reset_in,
  input wire logic ppb_write_in,
  input wire pdpsa_pkg::pdpsa_chan_t ppb_chan_in,
  input wire pdpsa_pkg::pdpsa_word_t ppb_wdata_in,
  input wire logic pci_write_in,
  input wire pdpsa_pkg::pdpsa_chan_t pci_chan_in,
  input wire pdpsa_pkg::pdpsa_word_t pci_wdata_in,
  input wire pdpsa_pkg::pdpsa_chan_t ppb_rchan_in,
  input wire pdpsa_pkg::pdpsa_chan_t pci_rchan_in,
  input wire logic [3:0] chan_start_in,
  input wire logic [3:0] addr_advance_in,
  output pdpsa_pkg::pdpsa_word_t ppb_rdata_out,
  output pdpsa_pkg::pdpsa_word_t pci_rdata_out,
  output pdpsa_pkg::pdpsa_word_t work_addr0_out,
  output pdpsa_pkg::pdpsa_word_t work_addr1_out,
  output pdpsa_pkg::pdpsa_word_t work_addr2_out,
  output pdpsa_pkg::pdpsa_word_t work_addr3_out
);
  import pdpsa_pkg::*;

  // ************************
  // State
  // ************************
  typedef struct packed {
    pdpsa_word_t [3:0] start;
    pdpsa_word_t [3:0] work;
    pdpsa_word_t ppb_rd;
    pdpsa_word_t pci_rd;
  } pdpsa_state_t;

  pdpsa_state_t st;
  pdpsa_state_t next_st;

  // Longword alignment of a programmed address
  function automatic pdpsa_word_t pdpsa_align(input pdpsa_word_t a);
    pdpsa_align = {a[31:`PDPSA_LOW_IGNORED], 2'h0};
  endfunction : pdpsa_align

  // Write strobe decode, shared by both bus ports
  function automatic logic pdpsa_hit(
    input logic wr,
    input pdpsa_chan_t chan,
    input int c
  );
    pdpsa_hit = wr && (chan == c[1:0]);
  endfunction : pdpsa_hit

  // Counter update: a start reloads, otherwise a data phase steps one longword.
  // Wraps at the top of the address space; the engine must end the burst first.
  function automatic pdpsa_word_t pdpsa_next_work(
    input logic load,
    input logic adv,
    input pdpsa_word_t reg_val,
    input pdpsa_word_t cur
  );
    if (load) begin
      pdpsa_next_work = pdpsa_align(reg_val);
    end else if (adv) begin
      pdpsa_next_work = cur + `PDPSA_STEP;
    end else begin
      pdpsa_next_work = cur;
    end
  endfunction : pdpsa_next_work

  // ************************
  // Next state
  // ************************
  always_comb begin
    next_st = st;
    for (int c = 0; c < `PDPSA_CHANNELS; c++) begin
      // PCI side wins a same-cycle collision; software must not race itself
      if (pdpsa_hit(ppb_write_in, ppb_chan_in, c)) begin
        next_st.start[c] = ppb_wdata_in;
      end
      if (pdpsa_hit(pci_write_in, pci_chan_in, c)) begin
        next_st.start[c] = pci_wdata_in;
      end
      // A start copies the register out and leaves it standing
      next_st.work[c] = pdpsa_next_work(chan_start_in[c], addr_advance_in[c],
        st.start[c],
        st.work[c]);
    end
    next_st.ppb_rd = st.start[ppb_rchan_in];
    next_st.pci_rd = st.start[pci_rchan_in];
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in || soft_reset_in) begin
      for (int c = 0; c < `PDPSA_CHANNELS; c++) begin
        st.start[c] <= `PDPSA_RESET_VAL;
        st.work[c] <= `PDPSA_RESET_VAL;
      end
      st.ppb_rd <= `PDPSA_RESET_VAL;
      st.pci_rd <= `PDPSA_RESET_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign ppb_rdata_out = st.ppb_rd;
  assign pci_rdata_out = st.pci_rd;
  assign work_addr0_out = st.work[0];
  assign work_addr1_out = st.work[1];
  assign work_addr2_out = st.work[2];
  assign work_addr3_out = st.work[3];

  // ************************
  // Checks
  // ************************
  a_start_loads_work: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && chan_start_in[0]) |=> work_addr0_out == {$past(st.start[0][31:2]), 2'h0})
    else $error("channel 0 counter not loaded on start");
  a_work_aligned: assert property (@(posedge clk_in) disable iff (!rstn_in)
    work_addr0_out[1:0] == 2'h0 && work_addr1_out[1:0] == 2'h0
      && work_addr2_out[1:0] == 2'h0 && work_addr3_out[1:0] == 2'h0)
    else $error("working address not longword aligned");
  a_soft_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
    soft_reset_in |=> st.start[3] == 32'h0 && ppb_rdata_out == 32'h0)
    else $error("soft reset did not clear");
  a_ppb_write_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ppb_write_in && !pci_write_in && !soft_reset_in && ppb_chan_in == 2'h1)
      ##1 (ppb_rchan_in == 2'h1 && !soft_reset_in)
      |=> ppb_rdata_out == $past(ppb_wdata_in, 2))
    else $error("peripheral write not read back");
  a_advance_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && !chan_start_in[2] && addr_advance_in[2])
      |=> work_addr2_out == $past(work_addr2_out) + 32'h4)
    else $error("counter did not advance by a longword");

  // ************************
  // Checks: counter loading
  // ************************
  a_chan1_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && chan_start_in[1])
      |=> work_addr1_out == {$past(st.start[1][31:2]), 2'h0})
    else $error("channel 1 counter not loaded on start");

  a_chan2_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && chan_start_in[2])
      |=> work_addr2_out == {$past(st.start[2][31:2]), 2'h0})
    else $error("channel 2 counter not loaded on start");

  a_chan3_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && chan_start_in[3])
      |=> work_addr3_out == {$past(st.start[3][31:2]), 2'h0})
    else $error("channel 3 counter not loaded on start");

  // Start must win over a data phase landing in the same cycle
  a_start_over_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && chan_start_in[1] && addr_advance_in[1])
      |=> work_addr1_out == {$past(st.start[1][31:2]), 2'h0})
    else $error("data phase overrode a channel start");

  a_start_keeps_reg: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && chan_start_in[0] && !ppb_write_in && !pci_write_in)
      |=> st.start[0] == $past(st.start[0]))
    else $error("start disturbed the programmed register");

  // ************************
  // Checks: counter stepping
  // ************************
  a_chan0_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && !chan_start_in[0] && addr_advance_in[0])
      |=> work_addr0_out == $past(work_addr0_out) + 32'h4)
    else $error("channel 0 counter did not step");

  a_chan1_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && !chan_start_in[1] && addr_advance_in[1])
      |=> work_addr1_out == $past(work_addr1_out) + 32'h4)
    else $error("channel 1 counter did not step");

  a_chan3_step: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && !chan_start_in[3] && addr_advance_in[3])
      |=> work_addr3_out == $past(work_addr3_out) + 32'h4)
    else $error("channel 3 counter did not step");

  // Counters may only move on a start or a data phase
  a_work_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (!soft_reset_in && chan_start_in == 4'h0 && addr_advance_in == 4'h0)
      |=> work_addr0_out == $past(work_addr0_out) && work_addr1_out == $past(work_addr1_out)
        && work_addr2_out == $past(work_addr2_out) && work_addr3_out == $past(work_addr3_out))
    else $error("working address moved while idle");

  // ************************
  // Checks: register access
  // ************************
  a_pci_write_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (pci_write_in && !soft_reset_in)
      ##1 (pci_rchan_in == $past(pci_chan_in) && !soft_reset_in)
      |=> pci_rdata_out == $past(pci_wdata_in, 2))
    else $error("PCI write not read back");

  a_pci_wins: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ppb_write_in && pci_write_in && ppb_chan_in == pci_chan_in && !soft_reset_in)
      ##1 (pci_rchan_in == $past(pci_chan_in) && !soft_reset_in)
      |=> pci_rdata_out == $past(pci_wdata_in, 2))
    else $error("PCI write lost a same-cycle collision");

  a_ppb_read_path: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !soft_reset_in |=> ppb_rdata_out == $past(st.start[ppb_rchan_in]))
    else $error("peripheral read data not from the selected register");

  a_pci_read_path: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !soft_reset_in |=> pci_rdata_out == $past(st.start[pci_rchan_in]))
    else $error("PCI read data not from the selected register");

  // ************************
  // Checks: reset
  // ************************
  a_reset_clears: assert property (@(posedge clk_in)
    !rstn_in |=> work_addr0_out == 32'h0 && work_addr1_out == 32'h0
      && work_addr2_out == 32'h0 && work_addr3_out == 32'h0
      && ppb_rdata_out == 32'h0 && pci_rdata_out == 32'h0)
    else $error("power-on reset left state behind");

  a_soft_clears_all: assert property (@(posedge clk_in) disable iff (!rstn_in)
    soft_reset_in |=> st.start == '0 && st.work == '0 && pci_rdata_out == 32'h0)
    else $error("soft reset left state behind");
endmodule : pdpsa_regs

// file: dv/pdpsa_target_model.sv
// Stand-in PCI target that accepts one data phase per burst cycle
`timescale 1ns/1ps
module pdpsa_target_model (
  input wire logic clk_in,
  input wire logic [3:0] burst_in,
  output logic [3:0] advance_out = 4'h0
);
  always @(posedge clk_in) advance_out <= burst_in;
endmodule : pdpsa_target_model

// file: dv/pdpsa_regs_tb.sv
// Self-checking bench for the DMA PCI start address registers
`timescale 1ns/1ps
module pdpsa_regs_tb;
  import pdpsa_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0, sr = 1'b0, ww = 1'b0, cw = 1'b0;
  logic [3:0] st = 4'h0, bu = 4'h0, adv;
  pdpsa_chan_t ch = 2'h0;
  pdpsa_word_t wd = 32'h0, pd = 32'h0, rp, rc, wa[4];
  pdpsa_word_t rows[4] = '{32'h12345677, 32'hfffffffe, 32'h80000001, 32'h4};
  int miscompares = 0, compares = 0, cyc = 0;
  always #4 clk_in = ~clk_in;
  pdpsa_target_model i_pdpsa_target_model (.clk_in(clk_in), .burst_in(bu), .advance_out(adv));
  pdpsa_regs i_pdpsa_regs (.clk_in(clk_in), .rstn_in(rstn_in), .soft_reset_in(sr),
    .ppb_write_in(ww), .ppb_chan_in(ch), .ppb_wdata_in(wd), .pci_write_in(cw),
    .pci_chan_in(ch), .pci_wdata_in(pd), .ppb_rchan_in(ch), .pci_rchan_in(ch),
    .chan_start_in(st), .addr_advance_in(adv), .ppb_rdata_out(rp), .pci_rdata_out(rc),
    .work_addr0_out(wa[0]), .work_addr1_out(wa[1]), .work_addr2_out(wa[2]),
    .work_addr3_out(wa[3]));
  task automatic n(input int k);
    repeat (k) @(negedge clk_in);
  endtask : n
  task automatic chk(input pdpsa_word_t s, input pdpsa_word_t e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Run needs about 50 cycles
  always @(posedge clk_in) if (++cyc == 2000) begin
    miscompares++;
    report_and_stop();
  end
  initial begin
    n(20);
    rstn_in = 1'b1;
    n(1);
    chk(rp, 32'h0);
    for (int i = 0; i < 4; i++) begin
      {ch, wd, pd} = {i[1:0], rows[i], rows[i]};
      {ww, cw} = i[0] ? 2'b01 : 2'b10;
      n(1);
      {ww, cw} = 2'b00;
      n(2);
      chk(rp, rows[i]);
      chk(rc, rows[i]);
      st[i] = 1'b1;
      n(1);
      st = 4'h0;
      chk(wa[i], rows[i] & 32'hfffffffc);
    end
    // Three phases wrap the counter past the top
    bu = 4'hf;
    n(3);
    bu = 4'h0;
    n(2);
    chk(wa[1], 32'h8);
    chk(wa[0], 32'h12345680);
    chk(wa[2], 32'h8000000c);
    chk(wa[3], 32'h10);
    // Reprogram and restart while a data phase is still landing
    {ch, wd, ww} = {2'h1, 32'h00001003, 1'b1};
    n(1);
    {ww, bu} = {1'b0, 4'h2};
    n(1);
    st = 4'h2;
    n(1);
    {st, bu} = 8'h00;
    chk(wa[1], 32'h1000);
    {wd, pd, ww, cw} = {32'haaaaaaaa, 32'h55555555, 2'b11};
    n(1);
    {ww, cw} = 2'b00;
    n(2);
    chk(rp, 32'h55555555);
    sr = 1'b1;
    n(1);
    sr = 1'b0;
    n(1);
    chk(rc, 32'h0);
    chk(wa[1], 32'h0);
    report_and_stop();
  end
endmodule : pdpsa_regs_tb
